// File: hdl/ddl_link.sv
// Serial link side: shift register and serial output on sclk.
// Assumes sclk only toggles while the host runs a frame.
`timescale 1ns/1ps
module ddl_link #(
  parameter int WORD_W = ddl_pkg::WORD_W
) (
  input wire logic sclk,
  input wire logic reset_n,
  input wire logic sync_n,
  input wire logic serial_data_in,
  input wire logic chain_mode_en,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  ddl_link_if.link lnk
);
  logic [WORD_W-1:0] shift_q;
  logic sout_q;
  logic chain_s;

  // Mode strap seen through two sclk flops
  ddl_sync #(.W(1), .RST(1'b0)) u_chain_sync (
    .clk(sclk),
    .reset_n(reset_n),
    .en(1'b1),
    .d(chain_mode_en),
    .q(chain_s)
  );

  // Sample on falling edge, host holds data there
  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= '0;
    end else if (!sync_n) begin
      shift_q <= {shift_q[WORD_W-2:0], serial_data_in};
    end
  end

  // Launch on rising edge, valid at next falling edge
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      sout_q <= 1'b0;
    end else begin
      sout_q <= shift_q[WORD_W-1];
    end
  end

  assign lnk.word = shift_q;
  assign serial_data_out = sout_q;
  assign serial_data_out_oe = chain_s;

  property shift_in_p;
    @(negedge sclk) disable iff (!reset_n)
      !sync_n |=> shift_q == {$past(shift_q[WORD_W-2:0]), $past(serial_data_in)};
  endproperty
  shift_bit_a: assert property (shift_in_p)
    else $error("shift register missed a serial bit");

  sout_source_a: assert property (
    @(negedge sclk) disable iff (!reset_n)
      !sync_n && $past(!sync_n) |-> serial_data_out == shift_q[WORD_W-1])
    else $error("serial output not the register top bit");

  sout_enable_a: assert property (
    @(posedge sclk) disable iff (!reset_n)
      $rose(serial_data_out_oe) |-> $past(chain_mode_en, 2))
    else $error("serial output enabled without chain mode");
endmodule

// File: hdl/ddl_link_if.sv
// Carrier between the serial link logic and the core.
// Word is only read by the core while the frame is idle.
`timescale 1ns/1ps
interface ddl_link_if #(parameter int WORD_W = ddl_pkg::WORD_W) ();
  logic [WORD_W-1:0] word;
  modport link (output word);
  modport core (input word);
endinterface

// File: hdl/ddl_pkg.sv
// Constants shared by the dual DAC serial load control block.
// Assumes a 100 MHz core clock and a serial link clocked by the host.
package ddl_pkg;
  localparam int DATA_W = 16;
  localparam int WORD_W = 24;
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADDR_A = 2'h0;
  localparam logic [1:0] ADDR_B = 2'h1;
  localparam logic [1:0] ADDR_BOTH = 2'h2;
  localparam int NUM_CH = 2;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_MAX_MHZ = 30;
  localparam int STROBE_AFTER_FRAME_NS = 130;
  localparam int STROBE_AFTER_FRAME_CYC =
    (STROBE_AFTER_FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_W = 6;
  localparam int PIN_SYNC = 5;
  localparam int PIN_STROBE = 4;
  localparam int PIN_ZERO = 3;
  localparam int PIN_MID = 2;
  localparam int PIN_CODING = 1;
  localparam int PIN_BIP = 0;
  localparam logic [5:0] PIN_RST = 6'h38;
  localparam logic DAC_RST_BIT = 1'b0;
endpackage

// File: hdl/ddl_sync.sv
// Two-stage synchroniser for a group of slow levels.
// Assumes inputs are static or change far slower than clk.
`timescale 1ns/1ps
module ddl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RST;
      sync_q <= RST;
    end else if (en) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// File: hdl/ddl_top.sv
// Dual DAC serial load control: input and DAC registers per channel.
// Assumes host serial link on sclk and slow control pins from board.
`timescale 1ns/1ps
module ddl_top #(
  parameter int DATA_W = ddl_pkg::DATA_W,
  parameter int WORD_W = ddl_pkg::WORD_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  input wire logic load_strobe_n,
  input wire logic output_zeroing_n,
  input wire logic clear_to_midscale,
  input wire logic bipolar_coding_select,
  input wire logic range_bipolar,
  input wire logic chain_mode_en,
  output logic [DATA_W-1:0] channel_a_output,
  output logic [DATA_W-1:0] channel_b_output
);
  localparam int NCH = ddl_pkg::NUM_CH;
  localparam int AW = ddl_pkg::ADDR_W;

  ddl_link_if #(.WORD_W(WORD_W)) lnk ();

  logic [ddl_pkg::PIN_W-1:0] pins;
  logic [ddl_pkg::PIN_W-1:0] pins_s;
  logic sync_s;
  logic strobe_s;
  logic zero_n_s;
  logic mid_s;
  logic coding_s;
  logic bip_s;
  logic sync_prev_q;
  logic strobe_prev_q;
  logic latch_p;
  logic strobe_fall;
  logic direct;
  logic [DATA_W-1:0] word_data;
  logic [AW-1:0] word_addr;
  logic [DATA_W-1:0] conv_data;
  logic [DATA_W-1:0] clear_code;
  logic [DATA_W-1:0] in_q [NCH];
  logic [DATA_W-1:0] dac_q [NCH];
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] wr;

  // Channel address decode, used only by the write enables
  function automatic logic hits(input logic [AW-1:0] a, input int ch);
    logic [AW-1:0] own;
    own = (ch == 0) ? ddl_pkg::ADDR_A : ddl_pkg::ADDR_B;
    return (a == ddl_pkg::ADDR_BOTH) || (a == own);
  endfunction

  // Map host code to straight binary for the converter
  function automatic logic [DATA_W-1:0] to_straight(
    input logic [DATA_W-1:0] code,
    input logic bip,
    input logic sel
  );
    logic [DATA_W-1:0] r;
    r = code;
    if (bip && !sel) begin
      r = {~code[DATA_W-1], code[DATA_W-2:0]};
    end
    return r;
  endfunction

  ddl_link #(.WORD_W(WORD_W)) u_link (
    .sclk(sclk),
    .reset_n(reset_n),
    .sync_n(sync_n),
    .serial_data_in(serial_data_in),
    .chain_mode_en(chain_mode_en),
    .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe),
    .lnk(lnk.link)
  );

  // Frame, strobe, clear and coding straps cross into clk here; the chain strap stays on sclk
  assign pins = {sync_n, load_strobe_n, output_zeroing_n,
                 clear_to_midscale, bipolar_coding_select, range_bipolar};

  ddl_sync #(.W(ddl_pkg::PIN_W), .RST(ddl_pkg::PIN_RST)) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .en(ce),
    .d(pins),
    .q(pins_s)
  );

  assign sync_s = pins_s[ddl_pkg::PIN_SYNC];
  assign strobe_s = pins_s[ddl_pkg::PIN_STROBE];
  assign zero_n_s = pins_s[ddl_pkg::PIN_ZERO];
  assign mid_s = pins_s[ddl_pkg::PIN_MID];
  assign coding_s = pins_s[ddl_pkg::PIN_CODING];
  assign bip_s = pins_s[ddl_pkg::PIN_BIP];

  // Edge history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_prev_q <= 1'b1;
      strobe_prev_q <= 1'b1;
    end else if (ce) begin
      sync_prev_q <= sync_s;
      strobe_prev_q <= strobe_s;
    end
  end

  // Word is quiet here: sclk stops while the frame is high
  assign latch_p = ce && sync_s && !sync_prev_q;
  assign strobe_fall = ce && strobe_prev_q && !strobe_s;
  assign direct = !strobe_s;

  assign word_data = lnk.word[DATA_W-1:0];
  assign word_addr = lnk.word[DATA_W +: AW];
  assign conv_data = to_straight(word_data, bip_s, coding_s);
  assign clear_code = mid_s ? {1'b1, {(DATA_W-1){1'b0}}} : '0;

  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    assign wr[ch] = latch_p && hits(word_addr, ch);

    // Input register takes every addressed write
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        in_q[ch] <= {DATA_W{ddl_pkg::DAC_RST_BIT}};
      end else if (wr[ch]) begin
        in_q[ch] <= conv_data;
      end
    end

    // Pending flag: a deferred write waits for the strobe edge
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        pend_q[ch] <= 1'b0;
      end else if (wr[ch] && !direct) begin
        pend_q[ch] <= 1'b1;
      end else if (strobe_fall || wr[ch]) begin
        pend_q[ch] <= 1'b0;
      end
    end

    // DAC register: clear first, then direct write, then strobe
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        dac_q[ch] <= {DATA_W{ddl_pkg::DAC_RST_BIT}};
      end else if (ce) begin
        if (!zero_n_s) begin
          dac_q[ch] <= clear_code;
        end else if (wr[ch] && direct) begin
          dac_q[ch] <= conv_data;
        end else if (strobe_fall && pend_q[ch]) begin
          dac_q[ch] <= in_q[ch];
        end
      end
    end
  end

  assign channel_a_output = dac_q[0];
  assign channel_b_output = dac_q[1];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence direct_a_write_s;
    wr[0] && direct && zero_n_s;
  endsequence

  // Code mapping checks, then general write, strobe and clear checks

  twos_code_a: assert property (
    direct_a_write_s and (bip_s && !coding_s)
      |=> channel_a_output ==
          {~$past(word_data[DATA_W-1]), $past(word_data[DATA_W-2:0])})
    else $error("twos complement code not mapped");

  offset_code_a: assert property (
    direct_a_write_s and (bip_s && coding_s)
      |=> channel_a_output == $past(word_data))
    else $error("offset binary code altered");

  unipolar_code_a: assert property (
    direct_a_write_s and !bip_s
      |=> channel_a_output == $past(word_data))
    else $error("unipolar code altered");

  frame_only_a: assert property (
    !latch_p && !strobe_fall && zero_n_s
      |=> $stable(channel_a_output) && $stable(channel_b_output))
    else $error("DAC changed without frame, strobe or clear");

  direct_b_a: assert property (
    wr[1] && direct && zero_n_s
      |=> channel_b_output == $past(conv_data) && !pend_q[1])
    else $error("direct write did not reach channel B");

  defer_hold_a: assert property (
    wr[0] && !direct && zero_n_s
      |=> pend_q[0] && $stable(channel_a_output)
          && in_q[0] == $past(conv_data))
    else $error("deferred write touched the DAC register");

  strobe_both_a: assert property (
    strobe_fall && zero_n_s && pend_q == 2'h3 && !wr[0] && !wr[1]
      |=> channel_a_output == $past(in_q[0])
          && channel_b_output == $past(in_q[1]) && pend_q == 2'h0)
    else $error("strobe did not move both channels together");

  clear_force_a: assert property (
    ce && !zero_n_s
      |=> channel_a_output == $past(clear_code)
          && channel_b_output == $past(clear_code))
    else $error("clear did not force the DAC registers");

  clear_pin_a: assert property (
    ce [*4] ##0 (!output_zeroing_n && !clear_to_midscale) [*4]
      |=> channel_a_output == '0 && channel_b_output == '0)
    else $error("clear pin ignored without serial activity");

  // Write path checks
  direct_a_a: assert property (
    wr[0] && direct && zero_n_s
      |=> channel_a_output == $past(conv_data) && !pend_q[0])
    else $error("direct write did not reach channel A");

  defer_b_a: assert property (
    wr[1] && !direct && zero_n_s
      |=> pend_q[1] && $stable(channel_b_output)
          && in_q[1] == $past(conv_data))
    else $error("deferred write touched channel B");

  in_write_a: assert property (
    wr[0]
      |=> in_q[0] == $past(conv_data))
    else $error("input register missed an addressed write");

  no_target_a: assert property (
    latch_p && word_addr == 2'h3 && !strobe_fall && zero_n_s
      |=> $stable(channel_a_output) && $stable(channel_b_output))
    else $error("write to no channel changed an output");

  both_same_a: assert property (
    latch_p && word_addr == ddl_pkg::ADDR_BOTH && direct && zero_n_s
      |=> channel_a_output == channel_b_output)
    else $error("write to both channels left them unequal");

  // Strobe checks
  strobe_a_a: assert property (
    strobe_fall && pend_q[0] && !wr[0] && zero_n_s
      |=> channel_a_output == $past(in_q[0]))
    else $error("strobe did not move channel A");

  strobe_b_a: assert property (
    strobe_fall && pend_q[1] && !wr[1] && zero_n_s
      |=> channel_b_output == $past(in_q[1]))
    else $error("strobe did not move channel B");

  strobe_idle_a: assert property (
    strobe_fall && pend_q == 2'h0 && !latch_p && zero_n_s
      |=> $stable(channel_a_output) && $stable(channel_b_output))
    else $error("strobe moved a channel with nothing pending");

  strobe_clears_a: assert property (
    strobe_fall && !wr[0] && !wr[1]
      |=> pend_q == 2'h0)
    else $error("pending flags survived the strobe");

  // Clear checks
  mid_code_a: assert property (
    ce && !zero_n_s && mid_s
      |=> channel_a_output == {1'b1, {(DATA_W-1){1'b0}}}
          && channel_b_output == {1'b1, {(DATA_W-1){1'b0}}})
    else $error("clear did not give the midscale code");

  zero_code_a: assert property (
    ce && !zero_n_s && !mid_s
      |=> channel_a_output == '0 && channel_b_output == '0)
    else $error("clear did not give the zero code");

  pend_kept_a: assert property (
    !zero_n_s && !strobe_fall && !wr[0] && pend_q[0]
      |=> pend_q[0])
    else $error("clear dropped a pending write");

  // Clock enable low freezes the clk side
  ce_freeze_a: assert property (
    !ce
      |=> $stable(channel_a_output) && $stable(channel_b_output)
          && $stable(pend_q))
    else $error("state moved while the clock enable was low");

  direct_c: cover property (wr[0] && direct && zero_n_s);
  deferred_c: cover property (wr[1] && !direct ##[1:200] strobe_fall);
  both_c: cover property (strobe_fall && pend_q == 2'h3);
  clear_mid_c: cover property (!zero_n_s && mid_s);
  twos_c: cover property (wr[0] && bip_s && !coding_s);
endmodule

// File: tb/ddl_host_model.sv
// Host model: drives frame, serial clock and data, and captures serial out.
// Assumes the device samples data on falling sclk while sync_n is low.
`timescale 1ns/1ps
module ddl_host_model #(
  parameter int WORD_W = 24,
  parameter int HALF_NS = 24
) (
  output logic sclk,
  output logic sync_n,
  output logic din,
  input wire logic dout
);
  // Clock idles high between frames
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b0;
  end

  // Period 48 ns stays under the 30 MHz ceiling
  task automatic send(input logic [WORD_W-1:0] w, output logic [WORD_W-1:0] rb);
    sync_n = 1'b0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      // Data set mid high phase, stable across the falling edge
      #(HALF_NS / 2) din = w[i];
      #(HALF_NS / 2) rb[i] = dout;
      sclk = 1'b0;
      #HALF_NS sclk = 1'b1;
    end
    #HALF_NS sync_n = 1'b1;
    // Released line shows the inverse of the last bit
    din = ~din;
    #200;
  endtask
endmodule

// File: tb/tb.sv
// Testbench for the dual DAC serial load control block.
// Assumes the host model on the link and static straps changed between frames.
`timescale 1ns/1ps
module tb;
  localparam int DW = ddl_pkg::DATA_W;
  localparam int WW = ddl_pkg::WORD_W;
  logic clk, reset_n, sclk, sync_n, din, dout, dout_oe;
  logic ld_n, zero_n, mid, coding, bip, chain;
  logic [DW-1:0] out_a, out_b;
  int fails = 0;
  int checks_done = 0;

  ddl_top dut (
    .clk(clk), .reset_n(reset_n), .ce(1'b1), .sclk(sclk), .sync_n(sync_n),
    .serial_data_in(din), .serial_data_out(dout), .serial_data_out_oe(dout_oe),
    .load_strobe_n(ld_n), .output_zeroing_n(zero_n), .clear_to_midscale(mid),
    .bipolar_coding_select(coding), .range_bipolar(bip), .chain_mode_en(chain),
    .channel_a_output(out_a), .channel_b_output(out_b)
  );
  ddl_host_model #(.WORD_W(WW)) host (.sclk(sclk), .sync_n(sync_n), .din(din), .dout(dout));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [WW-1:0] got, input logic [WW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [1:0] adr, input logic [DW-1:0] d);
    logic [WW-1:0] rb;
    host.send({{(WW - DW - 2){1'b0}}, adr, d}, rb);
    repeat (10) @(negedge clk);
  endtask

  task automatic t_direct;
    put(ddl_pkg::ADDR_A, 16'h1234);
    chk(WW'(out_a), 24'h001234);
    put(ddl_pkg::ADDR_B, 16'hfedc);
    chk(WW'(out_b), 24'h00fedc);
    put(ddl_pkg::ADDR_BOTH, 16'h00ff);
    chk(WW'(out_a), 24'h0000ff);
    chk(WW'(out_b), 24'h0000ff);
    put(2'h3, 16'h5555);
    chk(WW'(out_a), 24'h0000ff);
    chk(WW'(out_b), 24'h0000ff);
    chk(WW'(dout_oe), 24'h0);
  endtask

  task automatic t_coding;
    bip = 1'b1;
    repeat (4) @(negedge clk);
    put(ddl_pkg::ADDR_A, 16'h1234);
    chk(WW'(out_a), 24'h001234);
    coding = 1'b0;
    repeat (4) @(negedge clk);
    put(ddl_pkg::ADDR_A, 16'h1234);
    chk(WW'(out_a), 24'h009234);
    coding = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_defer;
    ld_n = 1'b1;
    repeat (4) @(negedge clk);
    put(ddl_pkg::ADDR_A, 16'haaaa);
    put(ddl_pkg::ADDR_B, 16'h5555);
    chk(WW'(out_a), 24'h009234);
    chk(WW'(out_b), 24'h0000ff);
    ld_n = 1'b0;
    for (int i = 0; i < 20 && out_a !== 16'haaaa; i++)
      @(negedge clk);
    chk(WW'(out_a), 24'h00aaaa);
    chk(WW'(out_b), 24'h005555);
  endtask

  task automatic t_clear;
    mid = 1'b1;
    zero_n = 1'b0;
    repeat (5) @(negedge clk);
    chk(WW'(out_b), 24'h008000);
    chk(WW'(out_a), 24'h008000);
    mid = 1'b0;
    repeat (5) @(negedge clk);
    chk(WW'(out_a), 24'h000000);
    zero_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_chain;
    logic [WW-1:0] rb;
    chain = 1'b1;
    repeat (4) @(negedge clk);
    host.send(24'hc3a5f0, rb);
    host.send(24'h3f0f0f, rb);
    chk(rb, 24'hc3a5f0);
    chk(WW'(dout_oe), 24'h1);
  endtask

  initial begin
    reset_n = 1'b0;
    ld_n = 1'b0;
    zero_n = 1'b1;
    mid = 1'b0;
    coding = 1'b1;
    bip = 1'b0;
    chain = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    repeat (5) @(negedge clk);
    t_direct();
    t_coding();
    t_defer();
    t_clear();
    t_chain();
    report_and_stop();
  end

  // About 10 frames of 1.4 us each are expected
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
endmodule
